// ### logic/pcmp_top.v
// two gpio ports with the port b analog comparator front end and register port
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
//
// What this block does
// - full reset leaves both port output value registers untouched
// - full reset clears both direction registers, making every pin an input
// - full reset makes both input registers take a fresh sample of the pins
// - full reset clears both special function registers, disabling alternate functions
// - stop recovery and watchdog timeout never alter any port control register
// - comparator active only when port b special function bits 3 and 4 set
// - comparator on: input bit 4 is synced result, bit 3 the reference pin level sampled like any other pin
// - comparator selected: bit 4 interrupt follows the comparator, not the raw pin
// - result high when signal above reference, low when below
// - comparator runs during halt; its enabled interrupt wakes the device
// - in stop the comparator is powered down and yields no new results
//
`include "pcmp_map.vh"

module pcmp_top (
    input wire core_clk_i,
    input wire rst_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [7:0] pa_pin_i,
    output reg [7:0] pa_pin_o,
    output reg [7:0] pa_pin_oe_n_o,
    input wire [7:0] pb_pin_i,
    output reg [7:0] pb_pin_o,
    output reg [7:0] pb_pin_oe_n_o,
    input wire cmp_result_i,
    output reg cmp_power_o,
    input wire halt_i,
    input wire stop_i,
    input wire stop_wake_recovery_i,
    input wire watchdog_timer_i,
    output reg irq_o,
    output reg wake_o
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] port_a_output_value_q;
reg [7:0] pa_dir_q;
reg [7:0] pa_func_q;
reg [7:0] pa_in_q;
reg [7:0] port_b_output_value_q;
reg [7:0] pb_dir_q;
reg [7:0] pb_func_q;
reg [7:0] pb_in_q;
reg [7:0] pb_prev_q;
reg init_q;
reg [7:0] irq_stat_q;
reg [7:0] irq_mask_q;
reg cmp_s1_q;
reg cmp_s2_q;

reg [7:0] irq_stat_d;
reg [7:0] pb_in_d;
reg [7:0] rdata_d;

wire wr_pa_out;
wire wr_pa_dir;
wire wr_pa_func;
wire wr_pb_out;
wire wr_pb_dir;
wire wr_pb_func;
wire wr_stat;
wire wr_mask;
wire cmp_on;
wire [7:0] pb_event;
wire [7:0] pa_drive;
wire [7:0] pb_drive;

assign wr_pa_out = wr_i && (addr_i == `PCMP_PA_OUT_ADDR);
assign wr_pa_dir = wr_i && (addr_i == `PCMP_PA_DIR_ADDR);
assign wr_pa_func = wr_i && (addr_i == `PCMP_PA_FUNC_ADDR);
assign wr_pb_out = wr_i && (addr_i == `PCMP_PB_OUT_ADDR);
assign wr_pb_dir = wr_i && (addr_i == `PCMP_PB_DIR_ADDR);
assign wr_pb_func = wr_i && (addr_i == `PCMP_PB_FUNC_ADDR);
assign wr_stat = wr_i && (addr_i == `PCMP_IRQ_STAT_ADDR);
assign wr_mask = wr_i && (addr_i == `PCMP_IRQ_MASK_ADDR);

// both function bits are needed; a single one leaves the pins digital
assign cmp_on = pb_func_q[`PCMP_CMP_SIG_BIT] & pb_func_q[`PCMP_CMP_REF_BIT];

////////////////////////////////////////////////////////////////////////////////
// output value registers carry no reset at all

always @(posedge core_clk_i) begin
    if (wr_pa_out) begin
        port_a_output_value_q <= wdata_i;
    end
    if (wr_pb_out) begin
        port_b_output_value_q <= wdata_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers: only the reset pin clears them

// stop recovery and watchdog inputs are deliberately not wired in here
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        pa_dir_q <= `PCMP_DIR_RST;
        pb_dir_q <= `PCMP_DIR_RST;
        pa_func_q <= `PCMP_FUNC_RST;
        pb_func_q <= `PCMP_FUNC_RST;
        irq_mask_q <= `PCMP_IRQ_RST;
    end else begin
        if (wr_pa_dir) begin
            pa_dir_q <= wdata_i;
        end
        if (wr_pb_dir) begin
            pb_dir_q <= wdata_i;
        end
        if (wr_pa_func) begin
            pa_func_q <= wdata_i;
        end
        if (wr_pb_func) begin
            pb_func_q <= wdata_i;
        end
        if (wr_mask) begin
            irq_mask_q <= wdata_i;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// comparator synchronizer

// frozen in stop: the front end is unpowered, its output is meaningless
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        cmp_s1_q <= 1'b0;
        cmp_s2_q <= 1'b0;
    end else if (!stop_i) begin
        cmp_s1_q <= cmp_result_i;
        cmp_s2_q <= cmp_s1_q;
    end
end

// power the front end only when selected and not stopped
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        cmp_power_o <= 1'b0;
    end else begin
        cmp_power_o <= cmp_on & ~stop_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// input value registers

// high result means signal above reference, taken as is
always @* begin
    pb_in_d = pb_pin_i;
    if (cmp_on) begin
        pb_in_d[`PCMP_CMP_SIG_BIT] = cmp_s2_q;
        pb_in_d[`PCMP_CMP_REF_BIT] = pb_pin_i[`PCMP_CMP_REF_BIT];
    end
end

// an async reset cannot load pins, so the fresh sample lands at the first edge
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        pa_in_q <= `PCMP_IN_RST;
        pb_in_q <= `PCMP_IN_RST;
        pb_prev_q <= `PCMP_IN_RST;
        init_q <= 1'b0;
    end else begin
        pa_in_q <= pa_pin_i;
        pb_in_q <= pb_in_d;
        init_q <= 1'b1;
        // first sample after reset primes history, so no false edges
        if (init_q) begin
            pb_prev_q <= pb_in_q;
        end else begin
            pb_prev_q <= pb_in_d;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: rising edges of the port b input register

// bit 4 of the input register already carries the comparator when selected
assign pb_event = pb_in_q & ~pb_prev_q;

// set wins over a simultaneous write-one-to-clear
always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
        irq_stat_d = irq_stat_d & ~wdata_i;
    end
    irq_stat_d = irq_stat_d | pb_event;
end

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        irq_stat_q <= `PCMP_IRQ_RST;
        irq_o <= 1'b0;
        wake_o <= 1'b0;
    end else begin
        irq_stat_q <= irq_stat_d;
        irq_o <= |(irq_stat_d & irq_mask_q);
        // halt leaves the clock running, so a pending request still wakes
        wake_o <= halt_i & (|(irq_stat_d & irq_mask_q));
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers

// analog pins never drive while the comparator owns them
assign pa_drive = pa_dir_q;
assign pb_drive = pb_dir_q & ~({8{cmp_on}} &
    ((8'h01 << `PCMP_CMP_SIG_BIT) | (8'h01 << `PCMP_CMP_REF_BIT)));

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
        always @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
                pa_pin_o[gi] <= 1'b0;
                pb_pin_o[gi] <= 1'b0;
                pa_pin_oe_n_o[gi] <= 1'b1;
                pb_pin_oe_n_o[gi] <= 1'b1;
            end else begin
                // gated so an output register reaches a pin only where its direction bit is set
                pa_pin_o[gi] <= pa_drive[gi] & port_a_output_value_q[gi];
                pb_pin_o[gi] <= pb_drive[gi] & port_b_output_value_q[gi];
                pa_pin_oe_n_o[gi] <= ~pa_drive[gi];
                pb_pin_oe_n_o[gi] <= ~pb_drive[gi];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read port

always @* begin
    rdata_d = `PCMP_UNMAPPED_RD;
    case (addr_i)
        `PCMP_PA_IN_ADDR: begin
            rdata_d = pa_in_q;
        end
        `PCMP_PA_OUT_ADDR: begin
            rdata_d = port_a_output_value_q;
        end
        `PCMP_PA_DIR_ADDR: begin
            rdata_d = pa_dir_q;
        end
        `PCMP_PA_FUNC_ADDR: begin
            rdata_d = pa_func_q;
        end
        `PCMP_PB_IN_ADDR: begin
            rdata_d = pb_in_q;
        end
        `PCMP_PB_OUT_ADDR: begin
            rdata_d = port_b_output_value_q;
        end
        `PCMP_PB_DIR_ADDR: begin
            rdata_d = pb_dir_q;
        end
        `PCMP_PB_FUNC_ADDR: begin
            rdata_d = pb_func_q;
        end
        `PCMP_IRQ_STAT_ADDR: begin
            rdata_d = irq_stat_q;
        end
        `PCMP_IRQ_MASK_ADDR: begin
            rdata_d = irq_mask_q;
        end
        `PCMP_CMP_STAT_ADDR: begin
            rdata_d[`PCMP_CST_ON_BIT] = cmp_on;
            rdata_d[`PCMP_CST_RES_BIT] = cmp_s2_q;
            rdata_d[`PCMP_CST_STOP_BIT] = stop_i;
            rdata_d[`PCMP_CST_HALT_BIT] = halt_i;
        end
        default: begin
            rdata_d = `PCMP_UNMAPPED_RD;
        end
    endcase
end

// data shows only in the cycle after the strobe, zero otherwise
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        rdata_o <= `PCMP_RDATA_RST;
    end else if (rd_i) begin
        rdata_o <= rdata_d;
    end else begin
        rdata_o <= `PCMP_RDATA_RST;
    end
end

endmodule

// ### logic/pcmp_map.vh
// register map, field positions and reset values of the port and comparator block
`ifndef PCMP_MAP_VH
`define PCMP_MAP_VH

`define PCMP_AW 8
`define PCMP_DW 8

// port a registers
`define PCMP_PA_IN_ADDR 8'hd0
`define PCMP_PA_OUT_ADDR 8'hd1
`define PCMP_PA_DIR_ADDR 8'hd2
`define PCMP_PA_FUNC_ADDR 8'hd3

// port b registers
`define PCMP_PB_IN_ADDR 8'hd4
`define PCMP_PB_OUT_ADDR 8'hd5
`define PCMP_PB_DIR_ADDR 8'hd6
`define PCMP_PB_FUNC_ADDR 8'hd7

// interrupt and status registers
`define PCMP_IRQ_STAT_ADDR 8'hd8
`define PCMP_IRQ_MASK_ADDR 8'hd9
`define PCMP_CMP_STAT_ADDR 8'hda

// comparator bits within port b
`define PCMP_CMP_SIG_BIT 4
`define PCMP_CMP_REF_BIT 3

// comparator status register fields
`define PCMP_CST_ON_BIT 0
`define PCMP_CST_RES_BIT 1
`define PCMP_CST_STOP_BIT 2
`define PCMP_CST_HALT_BIT 3

// reset values
`define PCMP_DIR_RST 8'h00
`define PCMP_FUNC_RST 8'h00
`define PCMP_IN_RST 8'h00
`define PCMP_IRQ_RST 8'h00
`define PCMP_RDATA_RST 8'h00
`define PCMP_UNMAPPED_RD 8'h00

`endif

// ### tb/pcmp_chk_sva.sv
// concurrent checks on the port and comparator block ports
`timescale 1ns/100ps
`include "pcmp_map.vh"
module pcmp_chk (
    input wire core_clk_i,
    input wire rst_i,
    input wire [7:0] addr_i,
    input wire rd_i,
    input wire wr_i,
    input wire [7:0] rdata_o,
    input wire [7:0] pa_pin_i,
    input wire [7:0] pa_pin_oe_n_o,
    input wire [7:0] pb_pin_oe_n_o,
    input wire cmp_power_o,
    input wire halt_i,
    input wire stop_i,
    input wire stop_wake_recovery_i,
    input wire watchdog_timer_i,
    input wire irq_o,
    input wire wake_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (rst_i);
a_dir_cleared: assert property ($fell(rst_i) |-> &{pa_pin_oe_n_o, pb_pin_oe_n_o})
    else $error("pin driven after reset");
a_func_cleared: assert property ($fell(rst_i) |-> !cmp_power_o)
    else $error("comparator on after reset");
a_in_sample: assert property (rd_i && addr_i == `PCMP_PA_IN_ADDR && !$past(rst_i)
    |=> rdata_o == $past(pa_pin_i, 2)) else $error("stale pin sample");
a_events_ignored: assert property ((stop_wake_recovery_i || watchdog_timer_i)
    && !wr_i && !$past(wr_i) |=> $stable(pa_pin_oe_n_o) && $stable(pb_pin_oe_n_o))
    else $error("direction moved on event");
a_stop_off: assert property (stop_i |=> !cmp_power_o)
    else $error("comparator powered in stop");
a_wake_cause: assert property (wake_o |-> irq_o && $past(halt_i))
    else $error("wake without halt or interrupt");
a_cmp_pins_free: assert property (cmp_power_o |-> pb_pin_oe_n_o[4:3] == 2'b11)
    else $error("comparator pins driven");
a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind pcmp_top pcmp_chk chk_u (.core_clk_i, .rst_i, .addr_i, .rd_i, .wr_i, .rdata_o,
    .pa_pin_i, .pa_pin_oe_n_o, .pb_pin_oe_n_o, .cmp_power_o, .halt_i, .stop_i,
    .stop_wake_recovery_i, .watchdog_timer_i, .irq_o, .wake_o);

// ### tb/pcmp_far.sv
// far side: pin levels outside both ports and the analog comparator front end
`timescale 1ns/100ps
module pcmp_far (
    input wire core_clk_i,
    input wire [7:0] pa_ext_i,
    input wire [7:0] pb_ext_i,
    input wire [7:0] pa_drv_i,
    input wire [7:0] pa_oe_n_i,
    input wire [7:0] pb_drv_i,
    input wire [7:0] pb_oe_n_i,
    input wire [15:0] sig_mv_i,
    input wire [15:0] ref_mv_i,
    input wire cmp_power_i,
    output wire [7:0] pa_level_o,
    output wire [7:0] pb_level_o,
    output wire cmp_result_o
);
reg toggle_q = 1'b0;
always @(posedge core_clk_i) begin
    toggle_q <= ~toggle_q;
end
assign pa_level_o = (pa_drv_i & ~pa_oe_n_i) | (pa_ext_i & pa_oe_n_i);
assign pb_level_o = (pb_drv_i & ~pb_oe_n_i) | (pb_ext_i & pb_oe_n_i);
// unpowered front end gives garbage, never a held result
assign cmp_result_o = cmp_power_i ? (sig_mv_i > ref_mv_i) : toggle_q;
endmodule

// ### tb/test_port_reset_and_comparator.sv
// testbench: register traffic, pin and comparator stimulus against a reference model
`timescale 1ns/100ps
`include "pcmp_map.vh"
module test_port_reset_and_comparator;
logic core_clk_i = 1'b0;
logic rst_i = 1'b1;
logic wr_i = 1'b0, rd_i = 1'b0, halt_i = 1'b0, stop_i = 1'b0, swr = 1'b0, wdt = 1'b0;
logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, pa_ext = 8'h00, pb_ext = 8'h00, d;
logic [15:0] sig_mv = 16'd0, ref_mv = 16'd1000;
wire [7:0] rdata_o, pa_pin_i, pa_pin_o, pa_oe_n, pb_pin_i, pb_pin_o, pb_oe_n;
wire cmp_result_i, cmp_power_o, irq_o, wake_o;
int err_count = 0;
int tests_run = 0;
int cycles = 0;
int mdl [int];
initial begin
    forever #5 core_clk_i = ~core_clk_i;
end
pcmp_top dut_u (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pa_pin_i,
    .pa_pin_o, .pa_pin_oe_n_o(pa_oe_n), .pb_pin_i, .pb_pin_o, .pb_pin_oe_n_o(pb_oe_n),
    .cmp_result_i, .cmp_power_o, .halt_i, .stop_i, .stop_wake_recovery_i(swr),
    .watchdog_timer_i(wdt), .irq_o, .wake_o);
pcmp_far far_u (.core_clk_i, .pa_ext_i(pa_ext), .pb_ext_i(pb_ext), .pa_drv_i(pa_pin_o),
    .pa_oe_n_i(pa_oe_n), .pb_drv_i(pb_pin_o), .pb_oe_n_i(pb_oe_n), .sig_mv_i(sig_mv),
    .ref_mv_i(ref_mv), .cmp_power_i(cmp_power_o), .pa_level_o(pa_pin_i),
    .pb_level_o(pb_pin_i), .cmp_result_o(cmp_result_i));
////////////////////////////////////////////////////////////////////////////////
task wrap_up;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
        err_count++;
        $display("wrong value %s expected %h seen %h", n, e, g);
    end
endtask
task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
endtask
task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    if (a inside {[8'hd1:8'hd3], [8'hd5:8'hd7], 8'hd9}) mdl[a] = v;
endtask
task cmpr(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata_o);
endtask
task sweep;
    foreach (mdl[k]) cmpr(8'(k), 8'(mdl[k]));
endtask
always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
        err_count++;
        wrap_up;
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    d = 8'($urandom(32'h3d84));
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cmpr(`PCMP_PA_DIR_ADDR, 8'h00);
    cmpr(`PCMP_PB_FUNC_ADDR, 8'h00);
    cmpr(8'hff, `PCMP_UNMAPPED_RD);
    wr(`PCMP_PA_OUT_ADDR, 8'($urandom));
    wr(`PCMP_PB_OUT_ADDR, 8'($urandom));
    wr(`PCMP_PA_DIR_ADDR, 8'hff);
    wr(`PCMP_PB_DIR_ADDR, 8'h0f);
    wr(`PCMP_PA_FUNC_ADDR, 8'h5a);
    tick(2);
    chk("pa pins", 8'(mdl[8'hd1]), pa_pin_o);
    rst_i <= 1'b1;
    tick(10);
    rst_i <= 1'b0;
    chk("pb oe", 8'hff, pb_oe_n);
    foreach (mdl[k]) if (k != 8'hd1 && k != 8'hd5) mdl[k] = 0;
    sweep;
    pa_ext <= 8'($urandom);
    tick(2);
    cmpr(`PCMP_PA_IN_ADDR, pa_ext);
    wr(`PCMP_PA_DIR_ADDR, 8'h3c);
    wr(`PCMP_PB_FUNC_ADDR, 8'h24);
    swr <= 1'b1;
    wdt <= 1'b1;
    tick(2);
    swr <= 1'b0;
    wdt <= 1'b0;
    sweep;
    // comparator on; power-up garbage is cleared before measuring
    pb_ext <= 8'h08;
    wr(`PCMP_PB_FUNC_ADDR, 8'h18);
    tick(8);
    wr(`PCMP_IRQ_STAT_ADDR, 8'hff);
    sig_mv <= 16'd800;
    tick(6);
    cmpr(`PCMP_PB_IN_ADDR, 8'h08);
    sig_mv <= 16'd1200;
    tick(6);
    cmpr(`PCMP_PB_IN_ADDR, 8'h18);
    cmpr(`PCMP_IRQ_STAT_ADDR, 8'h10);
    chk("masked irq", 8'h00, {7'h0, irq_o});
    halt_i <= 1'b1;
    wr(`PCMP_IRQ_MASK_ADDR, 8'h10);
    tick(2);
    chk("irq wake", 8'h03, {6'h0, irq_o, wake_o});
    cmpr(`PCMP_CMP_STAT_ADDR, 8'h0b);
    wr(`PCMP_IRQ_STAT_ADDR, 8'h10);
    halt_i <= 1'b0;
    tick(1);
    chk("cleared irq", 8'h00, {7'h0, irq_o});
    stop_i <= 1'b1;
    sig_mv <= 16'd800;
    tick(6);
    cmpr(`PCMP_PB_IN_ADDR, 8'h18);
    chk("power", 8'h00, {7'h0, cmp_power_o});
    // all of port b set to drive; the two analog pins must stay released
    wr(`PCMP_PB_DIR_ADDR, 8'hff);
    tick(2);
    chk("pb oe cmp", 8'h18, pb_oe_n);
    chk("pb pins", 8'(mdl[8'hd5]) & 8'he7, pb_pin_o);
    cmpr(`PCMP_CMP_STAT_ADDR, 8'h07);
    wr(`PCMP_PB_DIR_ADDR, 8'h00);
    stop_i <= 1'b0;
    wr(`PCMP_PB_FUNC_ADDR, 8'h10);
    tick(4);
    cmpr(`PCMP_PB_IN_ADDR, 8'h08);
    wrap_up;
end
endmodule
